// [hw/ursb_pkg.sv]
// Purpose: constants for the receive status and option block
// Assumes: apb with 32-bit data, 40 MHz pclk
// Notes: offsets are byte addresses
package ursb_pkg;
  localparam logic [7:0] URSB_OFF_CTRL = 8'h00;
  localparam logic [7:0] URSB_OFF_STAT = 8'h04;
  localparam logic [7:0] URSB_OFF_DATA = 8'h08;
  localparam logic [7:0] URSB_OFF_IRQ_STAT = 8'h0C;
  localparam logic [7:0] URSB_OFF_IRQ_MASK = 8'h10;
  // control bits
  localparam int URSB_CTRL_CONTINUOUS_RECEIVE_ENABLE = 0;
  localparam int URSB_CTRL_NINE = 1;
  localparam int URSB_CTRL_ADDR = 2;
  // status bits
  localparam int URSB_STAT_FRAMING_ERROR_FLAG = 2;
  localparam int URSB_STAT_OVERRUN_ERROR_FLAG = 1;
  localparam int URSB_STAT_B9 = 0;
  localparam int URSB_STAT_FULL = 3;
  // interrupt status bits
  localparam int URSB_IRQ_RX = 0;
  localparam int URSB_IRQ_FRAMING_ERROR_FLAG = 1;
  localparam int URSB_IRQ_OVERRUN_ERROR_FLAG = 2;
  localparam logic [2:0] URSB_CTRL_RESET = 3'h0;
  localparam logic [2:0] URSB_MASK_RESET = 3'h0;
  // serial timing
  localparam int URSB_CLK_HZ = 40000000;
  localparam int URSB_BAUD = 115200;
  localparam int URSB_BIT_CYCLES = URSB_CLK_HZ / URSB_BAUD;
  localparam int URSB_HALF_CYCLES = URSB_BIT_CYCLES / 2;
endpackage : ursb_pkg

// [hw/ursb_shifter.sv]
// Purpose: serial shifter, frames 8 or 9 data bits plus stop
// Assumes: rx pin already synchronised, idle high
// Notes: pulses done with data, ninth bit and stop level
`timescale 1ns/1ps
module ursb_shifter
  import ursb_pkg::*;
#(
  parameter int BIT_CYCLES = URSB_BIT_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic enable,
  input wire logic nine_bit_receive_select,
  input wire logic rx_in,
  // result
  output logic done,
  output logic [8:0] receive_shift_register,
  output logic stop_ok
);
  typedef enum logic [3:0] {
    URSB_IDLE = 4'h1,
    URSB_START = 4'h2,
    URSB_DATA = 4'h4,
    URSB_STOP = 4'h8
  } ursb_sh_e;
  localparam logic [15:0] BIT_LAST = 16'(BIT_CYCLES - 1);
  localparam logic [15:0] HALF_LAST = 16'(BIT_CYCLES / 2 - 1);
  ursb_sh_e state_q;
  logic [15:0] cnt_q;
  logic [3:0] idx_q;
  logic [3:0] nbits;
  assign nbits = nine_bit_receive_select ? 4'h9 : 4'h8;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= URSB_IDLE;
      cnt_q <= 16'h0000;
      idx_q <= 4'h0;
      receive_shift_register <= 9'h000;
      done <= 1'b0;
      stop_ok <= 1'b1;
    end else begin
      done <= 1'b0;
      case (state_q)
        URSB_IDLE: begin
          cnt_q <= 16'h0000;
          idx_q <= 4'h0;
          if (enable && !rx_in) begin
            state_q <= URSB_START;
          end
        end
        URSB_START: begin
          if (cnt_q == HALF_LAST) begin
            cnt_q <= 16'h0000;
            state_q <= rx_in ? URSB_IDLE : URSB_DATA;
            receive_shift_register <= 9'h000;
          end else begin
            cnt_q <= cnt_q + 16'h0001;
          end
        end
        URSB_DATA: begin
          if (cnt_q == BIT_LAST) begin
            cnt_q <= 16'h0000;
            receive_shift_register[idx_q] <= rx_in;
            idx_q <= idx_q + 4'h1;
            if (idx_q == nbits - 4'h1) begin
              state_q <= URSB_STOP;
            end
          end else begin
            cnt_q <= cnt_q + 16'h0001;
          end
        end
        URSB_STOP: begin
          if (cnt_q == BIT_LAST) begin
            stop_ok <= rx_in;
            done <= 1'b1;
            state_q <= URSB_IDLE;
          end else begin
            cnt_q <= cnt_q + 16'h0001;
          end
        end
        default: begin
          state_q <= URSB_IDLE;
        end
      endcase
    end
  end
endmodule : ursb_shifter

// [hw/ursb_top.sv]
// Purpose: receive status bits, address detect, apb registers
// Assumes: apb master keeps requests stable until pready
// Notes: single-entry receive buffer, zero-wait apb
//
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
// How it works
// - nine-bit mode without address detect keeps every byte.
// - in eight-bit mode the address detect setting does nothing.
// - framing flag shows the stop error of the byte last delivered.
// - overrun flag sets on a lost byte and clears only when continuous_receive_enable drops.
// - status bit 0 holds the ninth bit of the last nine-bit byte delivered.
// - nine-bit with address detect keeps only ninth-bit-set bytes.
module ursb_top
  import ursb_pkg::*;
#(
  parameter int BIT_CYCLES = ursb_pkg::URSB_BIT_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial line
  input wire logic rx_pin,
  // interrupt
  output logic irq
);
  import ursb_pkg::*;
  logic [2:0] sync_q;
  logic rx_level_q;
  logic [2:0] ctrl_q;
  logic [8:0] buf_q;
  logic buf_full_q;
  logic framing_error_flag_q;
  logic overrun_error_flag_q;
  logic received_ninth_bit_q;
  logic [2:0] irq_stat_q;
  logic [2:0] irq_mask_q;
  logic done;
  logic stop_ok;
  logic [8:0] shift_word;
  logic continuous_receive_enable;
  logic nine_bit_receive_select;
  logic address_detect_enable;
  logic acc;
  logic wr;
  logic rd_setup;
  logic rd_data;
  logic continuous_receive_enable_clear;
  logic unmapped;
  logic [31:0] rd_mux;
  logic [31:0] prdata_q;
  logic [2:0] irq_set;
  logic [2:0] irq_clr;
  logic keep;
  logic overrun_ev;
  logic deliver;

  assign continuous_receive_enable = ctrl_q[URSB_CTRL_CONTINUOUS_RECEIVE_ENABLE];
  assign nine_bit_receive_select = ctrl_q[URSB_CTRL_NINE];
  assign address_detect_enable = ctrl_q[URSB_CTRL_ADDR];
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  // reads act at setup, so the data and its side effect agree
  assign rd_setup = psel && !penable && !pwrite;
  assign rd_data = rd_setup && (paddr == URSB_OFF_DATA);
  assign continuous_receive_enable_clear = wr && (paddr == URSB_OFF_CTRL)
    && !pwdata[URSB_CTRL_CONTINUOUS_RECEIVE_ENABLE];
  assign pready = 1'b1;

  // pin synchroniser, change taken when stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_q <= 3'h7;
      rx_level_q <= 1'b1;
    end else begin
      sync_q <= {sync_q[1:0], rx_pin};
      if (sync_q[1] == sync_q[2]) begin
        rx_level_q <= sync_q[2];
      end
    end
  end

  ursb_shifter #(
    .BIT_CYCLES(BIT_CYCLES)
  ) i_ursb_shifter (
    .pclk(pclk),
    .presetn(presetn),
    .enable(continuous_receive_enable),
    .nine_bit_receive_select(nine_bit_receive_select),
    .rx_in(rx_level_q),
    .done(done),
    .receive_shift_register(shift_word),
    .stop_ok(stop_ok)
  );

  // address filter
  always_comb begin
    keep = 1'b1;
    if (nine_bit_receive_select && address_detect_enable) begin
      keep = shift_word[8];
    end
  end

  // a byte is dropped only while the buffer is still full
  assign overrun_ev = done && keep && buf_full_q && !rd_data;
  assign deliver = done && keep && !overrun_ev;

  // receive buffer, one entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_q <= 9'h000;
      buf_full_q <= 1'b0;
    end else if (deliver) begin
      buf_q <= shift_word;
      buf_full_q <= 1'b1;
    end else if (rd_data) begin
      buf_full_q <= 1'b0;
    end
  end

  // framing flag, refreshed per delivered byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      framing_error_flag_q <= 1'b0;
    end else if (deliver) begin
      framing_error_flag_q <= !stop_ok;
    end
  end

  // ninth bit, nine-bit frames only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      received_ninth_bit_q <= 1'b0;
    end else if (deliver && nine_bit_receive_select) begin
      received_ninth_bit_q <= shift_word[8];
    end
  end

  // overrun flag, set wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overrun_error_flag_q <= 1'b0;
    end else if (overrun_ev) begin
      overrun_error_flag_q <= 1'b1;
    end else if (!continuous_receive_enable || continuous_receive_enable_clear) begin
      overrun_error_flag_q <= 1'b0;
    end
  end

  // control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= URSB_CTRL_RESET;
    end else if (wr && paddr == URSB_OFF_CTRL) begin
      ctrl_q <= pwdata[2:0];
    end
  end

  // interrupt mask register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_q <= URSB_MASK_RESET;
    end else if (wr && paddr == URSB_OFF_IRQ_MASK) begin
      irq_mask_q <= pwdata[2:0];
    end
  end

  // event sources and write-one clears
  assign irq_set[URSB_IRQ_RX] = deliver;
  assign irq_set[URSB_IRQ_FRAMING_ERROR_FLAG] = deliver && !stop_ok;
  assign irq_set[URSB_IRQ_OVERRUN_ERROR_FLAG] = overrun_ev;
  assign irq_clr = (wr && paddr == URSB_OFF_IRQ_STAT) ? pwdata[2:0] : 3'h0;

  // sticky event bits, set wins over the clear
  for (genvar g = 0; g < 3; g++) begin : g_sticky
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        irq_stat_q[g] <= 1'b0;
      end else if (irq_set[g]) begin
        irq_stat_q[g] <= 1'b1;
      end else if (irq_clr[g]) begin
        irq_stat_q[g] <= 1'b0;
      end
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // read mux, unmapped reads zero with error
  always_comb begin
    rd_mux = 32'h0000_0000;
    unmapped = 1'b0;
    case (paddr)
      URSB_OFF_CTRL: rd_mux[2:0] = ctrl_q;
      URSB_OFF_STAT: begin
        rd_mux[URSB_STAT_FRAMING_ERROR_FLAG] = framing_error_flag_q;
        rd_mux[URSB_STAT_OVERRUN_ERROR_FLAG] = overrun_error_flag_q;
        rd_mux[URSB_STAT_B9] = received_ninth_bit_q;
        rd_mux[URSB_STAT_FULL] = buf_full_q;
      end
      URSB_OFF_DATA: rd_mux[8:0] = buf_q;
      URSB_OFF_IRQ_STAT: rd_mux[2:0] = irq_stat_q;
      URSB_OFF_IRQ_MASK: rd_mux[2:0] = irq_mask_q;
      default: unmapped = 1'b1;
    endcase
  end

  assign pslverr = acc && unmapped;

  // read data captured at setup, stands through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata_q <= rd_mux;
    end
  end

  assign prdata = prdata_q;
endmodule : ursb_top

// [verification/tb_ursb_top.sv]
// Purpose: bench for ursb_top
// Assumes: BIT_CYCLES of 8
// Notes: apb tasks and serial model
`timescale 1ns/1ps
module tb_ursb_top;
  import ursb_pkg::*;
  logic pclk, pready, pslverr, irq, rx_pin, serr;
  logic presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  int num_errors = 0;
  int tests_run = 0;
  ursb_top #(.BIT_CYCLES(8)) i_ursb_top (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_pin(rx_pin), .irq(irq));
  ursb_tx_model #(.BIT_CYCLES(8)) i_ursb_tx_model (.pclk(pclk), .rx(rx_pin));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task end_sim;
    if (num_errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 16);
    if (pready !== 1'b1) begin
      num_errors++;
      end_sim;
    end
    rdat = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    chk($sformatf("read %h", a), e, rdat & m);
  endtask : rd
  task ci(input logic e);
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask : ci
  task tx(input logic [8:0] d, input logic s);
    i_ursb_tx_model.send(d, 1'b1, s);
  endtask : tx
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    end_sim;
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(URSB_OFF_CTRL, 32'h0, 32'h7);
    rd(URSB_OFF_IRQ_MASK, 32'h0, 32'h7);
    rd(8'h14, 32'h0, 32'hFFFFFFFF);
    chk("slverr", 32'h1, {31'h0, serr});
    apb(1'b1, URSB_OFF_IRQ_MASK, 32'h7);
    apb(1'b1, URSB_OFF_CTRL, 32'h5);
    i_ursb_tx_model.send(9'h0A5, 1'b0, 1'b1);
    rd(URSB_OFF_STAT, 32'h8, 32'hF);
    ci(1'b1);
    rd(URSB_OFF_DATA, 32'hA5, 32'hFF);
    apb(1'b1, URSB_OFF_CTRL, 32'h3);
    tx(9'h03C, 1'b1);
    rd(URSB_OFF_STAT, 32'h8, 32'hF);
    rd(URSB_OFF_DATA, 32'h03C, 32'h1FF);
    tx(9'h1C3, 1'b1);
    rd(URSB_OFF_STAT, 32'h9, 32'hF);
    rd(URSB_OFF_DATA, 32'h1C3, 32'h1FF);
    apb(1'b1, URSB_OFF_CTRL, 32'h7);
    tx(9'h055, 1'b1);
    rd(URSB_OFF_STAT, 32'h0, 32'h8);
    tx(9'h1AA, 1'b1);
    rd(URSB_OFF_DATA, 32'h1AA, 32'h1FF);
    tx(9'h1F0, 1'b0);
    rd(URSB_OFF_STAT, 32'hD, 32'hF);
    rd(URSB_OFF_IRQ_STAT, 32'h3, 32'h7);
    rd(URSB_OFF_DATA, 32'h1F0, 32'h1FF);
    tx(9'h10F, 1'b1);
    rd(URSB_OFF_STAT, 32'h9, 32'hF);
    rd(URSB_OFF_DATA, 32'h10F, 32'h1FF);
    apb(1'b1, URSB_OFF_IRQ_STAT, 32'h7);
    ci(1'b0);
    tx(9'h044, 1'b1);
    ci(1'b0);
    tx(9'h111, 1'b1);
    tx(9'h122, 1'b1);
    rd(URSB_OFF_STAT, 32'hA, 32'hA);
    rd(URSB_OFF_DATA, 32'h111, 32'h1FF);
    rd(URSB_OFF_STAT, 32'h2, 32'h2);
    rd(URSB_OFF_IRQ_STAT, 32'h5, 32'h7);
    apb(1'b1, URSB_OFF_IRQ_MASK, 32'h0);
    ci(1'b0);
    apb(1'b1, URSB_OFF_IRQ_MASK, 32'h4);
    ci(1'b1);
    apb(1'b1, URSB_OFF_IRQ_STAT, 32'h4);
    ci(1'b0);
    apb(1'b1, URSB_OFF_CTRL, 32'h6);
    rd(URSB_OFF_STAT, 32'h0, 32'h2);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(URSB_OFF_CTRL, 32'h0, 32'h7);
    rd(URSB_OFF_IRQ_STAT, 32'h0, 32'h7);
    rd(URSB_OFF_STAT, 32'h0, 32'hF);
    ci(1'b0);
    end_sim;
  end
endmodule : tb_ursb_top

// [verification/ursb_top_props.sv]
// Purpose: apb and irq checks
// Assumes: zero-wait apb
// Notes: bound to ursb_top
`timescale 1ns/1ps
module ursb_top_props
  import ursb_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // interrupt
  input wire logic irq
);
  logic acc;
  logic seen_q;
  logic [2:0] ctrl_q;
  logic [2:0] mask_q;
  assign acc = psel && penable;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // shadow of control, mask and a seen overrun
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= URSB_CTRL_RESET;
      mask_q <= URSB_MASK_RESET;
      seen_q <= 1'b0;
    end else if (acc && pwrite) begin
      if (paddr == URSB_OFF_CTRL) begin
        ctrl_q <= pwdata[2:0];
        seen_q <= seen_q && pwdata[0];
      end
      if (paddr == URSB_OFF_IRQ_MASK) begin
        mask_q <= pwdata[2:0];
      end
    end else if (acc && paddr == URSB_OFF_STAT && prdata[1]) begin
      seen_q <= 1'b1;
    end
  end
  sequence s_rd(logic [7:0] a);
    acc && !pwrite && paddr == a;
  endsequence
  property p_ready; acc |-> pready; endproperty
  property p_bad;
    acc && paddr > URSB_OFF_IRQ_MASK |-> pslverr && (pwrite || !prdata);
  endproperty
  property p_ctrl; s_rd(URSB_OFF_CTRL) |-> prdata[2:0] == ctrl_q; endproperty
  property p_mask; s_rd(URSB_OFF_IRQ_MASK) |-> prdata[2:0] == mask_q;
  endproperty
  property p_irq_off; mask_q == 3'h0 |-> !irq; endproperty
  property p_ovr_off; s_rd(URSB_OFF_STAT) ##0 !ctrl_q[0] |-> !prdata[1];
  endproperty
  property p_ovr_hold;
    s_rd(URSB_OFF_STAT) ##0 (seen_q && ctrl_q[0]) |-> prdata[1];
  endproperty
  a_ready: assert property (p_ready) else $error("no ready");
  a_bad: assert property (p_bad) else $error("unmapped access");
  a_ctrl: assert property (p_ctrl) else $error("ctrl readback");
  a_mask: assert property (p_mask) else $error("mask readback");
  a_irq_off: assert property (p_irq_off) else $error("irq masked");
  a_ovr_off: assert property (p_ovr_off) else $error("overrun set");
  a_ovr_hold: assert property (p_ovr_hold) else $error("overrun lost");
endmodule : ursb_top_props
bind ursb_top ursb_top_props i_ursb_top_props (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .irq(irq));

// [verification/ursb_tx_model.sv]
// Purpose: remote serial transmitter
// Assumes: lsb first, one stop bit
// Notes: line idles high
`timescale 1ns/1ps
module ursb_tx_model #(
  parameter int BIT_CYCLES = 8
) (
  // clock
  input wire logic pclk,
  // serial line
  output logic rx
);
  initial rx = 1'b1;
  task automatic send(input logic [8:0] d, input logic nine, input logic s);
    rx <= 1'b0;
    repeat (BIT_CYCLES) @(posedge pclk);
    for (int i = 0; i < (nine ? 9 : 8); i++) begin
      rx <= d[i];
      repeat (BIT_CYCLES) @(posedge pclk);
    end
    rx <= s;
    repeat (BIT_CYCLES) @(posedge pclk);
    rx <= 1'b1;
    repeat (3 * BIT_CYCLES) @(posedge pclk);
  endtask : send
endmodule : ursb_tx_model
